// ### hdl/ssd_alu.v
// subtract with flag generation and nibble swap, purely combinational
`timescale 1ns/1ps
`include "ssd_regs.vh"

module ssd_alu (
	input  wire [7:0] minuend,
	input  wire [7:0] subtrahend,
	input  wire [7:0] swap_src,
	output wire [7:0] difference,
	output wire       carry_flag,
	output wire       half_carry_flag,
	output wire       zero_flag,
	output wire       overflow_flag,
	output wire [7:0] swapped
);
	wire [8:0] full_diff;
	wire [4:0] low_diff;

	assign full_diff       = {1'b0, minuend} - {1'b0, subtrahend};
	assign low_diff        = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
	assign difference      = full_diff[7:0];
	// borrow out of bit 7 clears carry, no borrow sets it
	assign carry_flag      = ~full_diff[8];
	assign half_carry_flag = low_diff[4];
	assign zero_flag       = (full_diff[7:0] == 8'h00);
	assign overflow_flag   = (minuend[7] ^ subtrahend[7]) &
	                         (full_diff[7] ^ minuend[7]);
	assign swapped         = {swap_src[3:0], swap_src[7:4]};
endmodule // ssd_alu

// ### hdl/ssd_regs.vh
// register map, field positions and codes for the subtract/swap datapath
`ifndef SSD_REGS_VH
`define SSD_REGS_VH

`define SSD_ADDR_W        12
`define SSD_DATA_W        32

`define SSD_CTRL_ADDR     12'h000
`define SSD_OPND_ADDR     12'h004
`define SSD_ACC_ADDR      12'h008
`define SSD_STAT_ADDR     12'h00C
`define SSD_MEM_BASE_HI   6'h01
`define SSD_MEM_DEPTH     16

`define SSD_CTRL_OP_LO    0
`define SSD_CTRL_OP_HI    1
`define SSD_CTRL_GO_BIT   4
`define SSD_OPND_IMM_LO   0
`define SSD_OPND_IMM_HI   7
`define SSD_OPND_IDX_LO   8
`define SSD_OPND_IDX_HI   11

`define SSD_OP_SUB_MEM    2'h0
`define SSD_OP_SUB_TO_MEM 2'h1
`define SSD_OP_SUB_IMM    2'h2
`define SSD_OP_SWAP       2'h3

`define SSD_FLAG_C        0
`define SSD_FLAG_AC       1
`define SSD_FLAG_Z        2
`define SSD_FLAG_OV       3

`define SSD_RESP_OKAY     2'h0
`define SSD_RESP_DECERR   2'h3

`define SSD_RST_BYTE      8'h00
`define SSD_RST_FLAGS     4'h0
`define SSD_RST_OP        2'h0
`define SSD_RST_IDX       4'h0
`define SSD_ZERO_WORD     32'h0000_0000

`endif

// ### hdl/ssd_top.v
// AXI4-Lite reachable accumulator datapath: three subtracts and nibble swap
// Functional notes
// - register-operand subtract writes accumulator minus memory byte to the accumulator.
// - memory-destination subtract writes accumulator minus memory byte back to that byte.
// - immediate subtract writes accumulator minus the immediate to the accumulator.
// - every subtract leaves carry 0 on a borrow and 1 when the difference is zero or positive.
// - swap exchanges the two nibbles of the addressed memory byte in place.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "ssd_regs.vh"

module ssd_top (
	input  wire                     clock,
	input  wire                     reset,
	input  wire [`SSD_ADDR_W-1:0]   s_axi_awaddr,
	input  wire [2:0]               s_axi_awprot,
	input  wire                     s_axi_awvalid,
	output reg                      s_axi_awready,
	input  wire [`SSD_DATA_W-1:0]   s_axi_wdata,
	input  wire [3:0]               s_axi_wstrb,
	input  wire                     s_axi_wvalid,
	output reg                      s_axi_wready,
	output reg  [1:0]               s_axi_bresp,
	output reg                      s_axi_bvalid,
	input  wire                     s_axi_bready,
	input  wire [`SSD_ADDR_W-1:0]   s_axi_araddr,
	input  wire [2:0]               s_axi_arprot,
	input  wire                     s_axi_arvalid,
	output reg                      s_axi_arready,
	output reg  [`SSD_DATA_W-1:0]   s_axi_rdata,
	output reg  [1:0]               s_axi_rresp,
	output reg                      s_axi_rvalid,
	input  wire                     s_axi_rready
);
	reg  [`SSD_ADDR_W-1:0]  waddr_r;
	reg  [`SSD_DATA_W-1:0]  wdata_r;
	reg  [3:0]              wstrb_r;
	reg                     aw_held_r;
	reg                     w_held_r;
	reg  [7:0]              accumulator_reg_r;
	reg  [3:0]              flags_r;
	reg  [1:0]              op_r;
	reg  [7:0]              imm_r;
	reg  [3:0]              idx_r;
	reg  [7:0]              mem_r [0:`SSD_MEM_DEPTH-1];

	wire                    commit;
	wire                    wr_ctrl;
	wire                    wr_opnd;
	wire                    wr_acc;
	wire                    wr_stat;
	wire                    wr_mem;
	wire                    wr_hit;
	wire                    go;
	wire [1:0]              go_op;
	wire [7:0]              mem_operand;
	wire [7:0]              subtrahend;
	wire [7:0]              difference;
	wire [7:0]              swapped;
	wire                    carry_flag;
	wire                    half_carry_flag;
	wire                    zero_flag;
	wire                    overflow_flag;
	wire                    exec_mem_we;
	wire [7:0]              exec_mem_data;
	reg  [`SSD_DATA_W-1:0]  rd_word;
	reg                     rd_hit;

	// write decode happens on the held address once both halves are in
	assign commit  = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_ctrl = commit & (waddr_r == `SSD_CTRL_ADDR) & wstrb_r[0];
	assign wr_opnd = commit & (waddr_r == `SSD_OPND_ADDR);
	assign wr_acc  = commit & (waddr_r == `SSD_ACC_ADDR) & wstrb_r[0];
	assign wr_stat = commit & (waddr_r == `SSD_STAT_ADDR) & wstrb_r[0];
	assign wr_mem  = commit & (waddr_r[11:6] == `SSD_MEM_BASE_HI) &
	                 wstrb_r[0];
	assign wr_hit  = (waddr_r == `SSD_CTRL_ADDR) |
	                 (waddr_r == `SSD_OPND_ADDR) |
	                 (waddr_r == `SSD_ACC_ADDR) |
	                 (waddr_r == `SSD_STAT_ADDR) |
	                 (waddr_r[11:6] == `SSD_MEM_BASE_HI);

	// execution runs in the same edge as the control write; operands are
	// whatever the operand register and memory hold at that moment
	assign go    = wr_ctrl & wdata_r[`SSD_CTRL_GO_BIT];
	assign go_op = wdata_r[`SSD_CTRL_OP_HI:`SSD_CTRL_OP_LO];

	assign mem_operand = mem_r[idx_r];
	assign subtrahend  = (go_op == `SSD_OP_SUB_IMM) ? imm_r
	                                                : mem_operand;

	ssd_alu u_alu (
		.minuend         (accumulator_reg_r),
		.subtrahend      (subtrahend),
		.swap_src        (mem_operand),
		.difference      (difference),
		.carry_flag      (carry_flag),
		.half_carry_flag (half_carry_flag),
		.zero_flag       (zero_flag),
		.overflow_flag   (overflow_flag),
		.swapped         (swapped)
	);

	assign exec_mem_we   = go & ((go_op == `SSD_OP_SUB_TO_MEM) |
	                             (go_op == `SSD_OP_SWAP));
	assign exec_mem_data = (go_op == `SSD_OP_SWAP) ? swapped
	                                               : difference;

	// write channel: address and data taken in either order
	always @(posedge clock) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SSD_RESP_OKAY;
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			waddr_r       <= {`SSD_ADDR_W{1'b0}};
			wdata_r       <= `SSD_ZERO_WORD;
			wstrb_r       <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				waddr_r       <= s_axi_awaddr;
				aw_held_r     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				w_held_r     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (commit) begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `SSD_RESP_OKAY : `SSD_RESP_DECERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// control and operand registers
	always @(posedge clock) begin
		if (reset) begin
			op_r  <= `SSD_RST_OP;
			imm_r <= `SSD_RST_BYTE;
			idx_r <= `SSD_RST_IDX;
		end else begin
			if (wr_ctrl)
				op_r <= go_op;
			if (wr_opnd & wstrb_r[0])
				imm_r <= wdata_r[`SSD_OPND_IMM_HI:`SSD_OPND_IMM_LO];
			if (wr_opnd & wstrb_r[1])
				idx_r <= wdata_r[`SSD_OPND_IDX_HI:`SSD_OPND_IDX_LO];
		end
	end

	// accumulator and flags; software writes never coincide with go
	always @(posedge clock) begin
		if (reset) begin
			accumulator_reg_r <= `SSD_RST_BYTE;
			flags_r           <= `SSD_RST_FLAGS;
		end else if (go) begin
			if (go_op == `SSD_OP_SUB_MEM) begin
				accumulator_reg_r <= difference;
			end else if (go_op == `SSD_OP_SUB_IMM) begin
				accumulator_reg_r <= difference;
			end
			// swap keeps flags; every subtract form loads all four
			if (go_op != `SSD_OP_SWAP) begin
				flags_r[`SSD_FLAG_C]  <= carry_flag;
				flags_r[`SSD_FLAG_AC] <= half_carry_flag;
				flags_r[`SSD_FLAG_Z]  <= zero_flag;
				flags_r[`SSD_FLAG_OV] <= overflow_flag;
			end
		end else begin
			if (wr_acc)
				accumulator_reg_r <= wdata_r[7:0];
			if (wr_stat)
				flags_r <= wdata_r[3:0];
		end
	end

	// data memory, one byte per entry
	genvar gi;
	generate
		for (gi = 0; gi < `SSD_MEM_DEPTH; gi = gi + 1) begin : g_mem
			always @(posedge clock) begin
				if (reset) begin
					mem_r[gi] <= `SSD_RST_BYTE;
				end else if (exec_mem_we && idx_r == gi) begin
					mem_r[gi] <= exec_mem_data;
				end else if (wr_mem && waddr_r[5:2] == gi) begin
					mem_r[gi] <= wdata_r[7:0];
				end
			end
		end
	endgenerate

	// read decode
	always @* begin
		rd_word = `SSD_ZERO_WORD;
		rd_hit  = 1'b1;
		if (s_axi_araddr == `SSD_CTRL_ADDR) begin
			rd_word[`SSD_CTRL_OP_HI:`SSD_CTRL_OP_LO] = op_r;
		end else if (s_axi_araddr == `SSD_OPND_ADDR) begin
			rd_word[`SSD_OPND_IMM_HI:`SSD_OPND_IMM_LO] = imm_r;
			rd_word[`SSD_OPND_IDX_HI:`SSD_OPND_IDX_LO] = idx_r;
		end else if (s_axi_araddr == `SSD_ACC_ADDR) begin
			rd_word[7:0] = accumulator_reg_r;
		end else if (s_axi_araddr == `SSD_STAT_ADDR) begin
			rd_word[3:0] = flags_r;
		end else if (s_axi_araddr[11:6] == `SSD_MEM_BASE_HI) begin
			rd_word[7:0] = mem_r[s_axi_araddr[5:2]];
		end else begin
			rd_hit = 1'b0;
		end
	end

	// read channel: data captured at the address handshake
	always @(posedge clock) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `SSD_ZERO_WORD;
			s_axi_rresp   <= `SSD_RESP_OKAY;
		end else begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_hit ? `SSD_RESP_OKAY : `SSD_RESP_DECERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // ssd_top

// ### verif/ssd_top_properties.sv
// handshake checker for the register port of the subtract/swap datapath
`timescale 1ns/1ps
module ssd_top_chk (
	input logic       clock,
	input logic       reset,
	input logic       s_axi_awvalid,
	input logic       s_axi_awready,
	input logic       s_axi_wvalid,
	input logic       s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic       s_axi_bvalid,
	input logic       s_axi_bready,
	input logic       s_axi_arvalid,
	input logic       s_axi_arready,
	input logic [1:0] s_axi_rresp,
	input logic       s_axi_rvalid,
	input logic       s_axi_rready
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// both halves taken together: commit edge, then the answer
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not freed");
	chk_w_refused: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready)
		else $error("read channel not freed");
	chk_bresp_codes: assert property (s_axi_bvalid |->
		s_axi_bresp inside {2'h0, 2'h3})
		else $error("bad write response code");
	chk_rresp_codes: assert property (s_axi_rvalid |->
		s_axi_rresp inside {2'h0, 2'h3})
		else $error("bad read response code");
endmodule // ssd_top_chk

bind ssd_top ssd_top_chk u_chk (.clock, .reset, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### verif/test_subtract_swap_datapath.sv
// self-checking bench for the subtract and nibble swap datapath
`timescale 1ns/1ps
`include "ssd_regs.vh"
module test_subtract_swap_datapath;
	typedef struct {logic [7:0] op, acc, mem, imm, pf, ea, em, ef;} ssd_row_t;
	logic        clock = 0;
	logic        reset = 1;
	logic [11:0] awaddr = 0;
	logic [11:0] araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          n_mismatch = 0, checks = 0, cyc = 0;
	ssd_row_t    rows [7];

	ssd_top dut (.clock(clock), .reset(reset), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	initial forever #2 clock = ~clock;

	task final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// whole run is a few hundred cycles; generous ceiling
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			final_report;
		end
	end

	task chk(input string nm, input [31:0] e, input [31:0] g);
		checks = checks + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// address and data offered together, each dropped once taken
	task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
		logic ad, wd;
		ad = 0;
		wd = 0;
		// one edge between calls so a strobe dropped by the last call is seen low
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && wd)) begin
			@(posedge clock);
			if (!ad && awready === 1'b1) begin
				ad = 1;
				awvalid <= 0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1;
				wvalid <= 0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clock);
		bready <= 0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	// data on a refused read is not defined, so only the code is compared
	task rd(input [11:0] a, input [31:0] e, input [1:0] er);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clock); while (rvalid !== 1'b1);
		rready <= 0;
		chk("rresp", 32'(er), 32'(rresp));
		if (er == 2'h0) chk("rdata", e, rdata);
	endtask

	initial begin
		logic [11:0] ma;
		rows[0] = '{8'h0, 8'h50, 8'h30, 8'h0, 8'hF, 8'h20, 8'h30, 8'h1};
		rows[1] = '{8'h1, 8'h30, 8'h50, 8'h0, 8'hF, 8'h30, 8'hE0, 8'h0};
		rows[2] = '{8'h2, 8'h80, 8'h00, 8'h1, 8'h0, 8'h7F, 8'h00, 8'hB};
		rows[3] = '{8'h2, 8'h42, 8'h00, 8'h42, 8'h0, 8'h00, 8'h00, 8'h5};
		rows[4] = '{8'h3, 8'h11, 8'hA5, 8'h0, 8'hA, 8'h11, 8'h5A, 8'hA};
		rows[5] = '{8'h0, 8'h10, 8'h01, 8'h0, 8'h0, 8'h0F, 8'h01, 8'h3};
		rows[6] = '{8'h1, 8'h7F, 8'hFF, 8'h0, 8'h0, 8'h7F, 8'h80, 8'h8};
		repeat (2) @(posedge clock);
		reset <= 0;
		rd(`SSD_ACC_ADDR, 32'h0, 2'h0);
		rd(`SSD_STAT_ADDR, 32'h0, 2'h0);
		for (int i = 0; i < 7; i++) begin
			ma = 12'h040 + 12'(4 * i);
			wr(`SSD_ACC_ADDR, 32'(rows[i].acc), 4'h1, 2'h0);
			wr(ma, 32'(rows[i].mem), 4'h1, 2'h0);
			wr(`SSD_STAT_ADDR, 32'(rows[i].pf), 4'h1, 2'h0);
			wr(`SSD_OPND_ADDR, {20'h0, 4'(i), rows[i].imm}, 4'h3, 2'h0);
			wr(`SSD_CTRL_ADDR, {27'h0, 1'b1, 2'h0, rows[i].op[1:0]}, 4'h1, 2'h0);
			rd(`SSD_ACC_ADDR, 32'(rows[i].ea), 2'h0);
			rd(ma, 32'(rows[i].em), 2'h0);
			rd(`SSD_STAT_ADDR, 32'(rows[i].ef), 2'h0);
		end
		// repeat the last operation on its own result, no reloading
		wr(`SSD_CTRL_ADDR, 32'h11, 4'h1, 2'h0);
		rd(12'h058, 32'hFF, 2'h0);
		rd(`SSD_STAT_ADDR, 32'h8, 2'h0);
		rd(`SSD_ACC_ADDR, 32'h7F, 2'h0);
		rd(`SSD_CTRL_ADDR, 32'h1, 2'h0);
		wr(12'h100, 32'hFF, 4'hF, 2'h3);
		rd(12'h100, 32'h0, 2'h3);
		rd(`SSD_ACC_ADDR, 32'h7F, 2'h0);
		// reset in mid-run must clear registers and memory again
		reset <= 1;
		repeat (2) @(posedge clock);
		reset <= 0;
		rd(`SSD_ACC_ADDR, 32'h0, 2'h0);
		rd(`SSD_STAT_ADDR, 32'h0, 2'h0);
		rd(`SSD_OPND_ADDR, 32'h0, 2'h0);
		rd(`SSD_CTRL_ADDR, 32'h0, 2'h0);
		rd(12'h058, 32'h0, 2'h0);
		final_report;
	end
endmodule // test_subtract_swap_datapath
